// file: hw/grd_receive_dma.v
// gpib receive path with byte-wise or dma delivery into host memory
`include "grd_defines.vh"

// Function
// - single mode: one byte per bus tenure
// - demand mode: release after request low three cycles
// - single and demand together is flagged and run as single
// - auto mode reloads count and address, repeats, dma only
// - auto mode disarms when next transfer completes
// - mode word: auto 1, demand 2, single 4
// - unloaded mode defaults to single, no auto
// - nonzero 32-bit count ends input
// - zero count: end only on terminators or halt
// - xfer word: bit0 dma, bit1 early return
// - early return after first byte, dma only, unless timeout zero
// - early plus auto: cycle until halt or terminator
// - eoi select: default, ignore or detect
// - terminator is one byte or two-byte sequence
// - first terminator override 0 to 255
// - second terminator override 0 to 255
// - default first forces default second
// - count and terminators: first one wins
module grd_receive_dma (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // dma mode configuration
  input  wire        dmaModeLoad,
  input  wire [15:0] dmaMode,
  // stored default terminators
  input  wire        dfltEoi,
  input  wire        dfltTerm1En,
  input  wire [7:0]  dfltTerm1,
  input  wire        dfltTerm2En,
  input  wire [7:0]  dfltTerm2,
  // call parameters, taken on start; halt_call acts while running
  input  wire        start,
  input  wire [15:0] xferMode,
  input  wire [31:0] byteCount,
  input  wire [7:0]  bufPage,
  input  wire [15:0] bufOffset,
  input  wire [15:0] eoiSel,
  input  wire [15:0] term1Sel,
  input  wire [15:0] term2Sel,
  input  wire        timeoutZero,
  input  wire        halt_call,
  // talker byte stream
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  input  wire        rxEoi,
  output wire        rxReady,
  // host memory bus
  output wire        dmaReq,
  output reg         busHold_q,
  output reg         memWr_q,
  output reg  [23:0] memAddr_q,
  output reg  [7:0]  memData_q,
  // programmed transfer data
  output reg         pioStrobe_q,
  output reg  [7:0]  pioData_q,
  // status
  output wire        busy,
  output reg         modeError_q,
  output reg         autoArmed_q,
  output reg         hostReturn_q,
  output reg         done_q,
  output reg  [1:0]  doneCause_q
);

  // ----------------------------------------------------------
  // states
  // ----------------------------------------------------------
  localparam S_IDLE = 2'h0;  // no transfer
  localparam S_WAIT = 2'h1;  // running, bus with processor
  localparam S_XFER = 2'h2;  // bus held, byte may move
  localparam S_HOLD = 2'h3;  // demand: held, request low

  // true when a selector asks for the stored default
  function isDflt;
    input [15:0] v;
    begin
      isDflt = (v == `GRD_SEL_DEFAULT) || (v[15:8] != 8'h00);
    end
  endfunction

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  reg [1:0]  state_q;      // sequencer state
  reg        single_q;     // one byte per tenure
  reg        dmaOn_q;      // this transfer uses dma
  reg        cont_q;       // early return selected
  reg        autoUse_q;    // reload at count end
  reg [31:0] count_q;      // programmed count
  reg [31:0] remain_q;     // bytes left in pass
  reg [15:0] startOff_q;   // reload offset
  reg [15:0] off_q;        // current offset in page
  reg [7:0]  page_q;       // fixed page of buffer
  reg        eoiUse_q;     // end on eoi
  reg        t1En_q;       // first terminator active
  reg [7:0]  t1_q;         // first terminator byte
  reg        t2En_q;       // two-byte sequence active
  reg [7:0]  t2_q;         // second terminator byte
  reg        prevT1_q;     // last byte matched first term
  reg        first_q;      // no early return given yet
  reg [1:0]  lowCnt_q;     // demand low-request cycles

  // ----------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------
  wire running = (state_q != S_IDLE);
  wire inBus   = (state_q == S_XFER) || (state_q == S_HOLD);
  // pio takes bytes whenever running; dma only while holding bus
  assign rxReady = running && (dmaOn_q ? inBus : 1'b1);
  assign dmaReq  = running && dmaOn_q && rxValid;
  assign busy    = running;
  wire take = rxValid && rxReady;

  // end conditions on the byte being taken
  wire eoiHit  = eoiUse_q && rxEoi;
  wire seqHit  = t2En_q ? (prevT1_q && rxData == t2_q)
                        : (t1En_q && rxData == t1_q);
  wire termHit = take && (eoiHit || seqHit);
  // zero count never matches, so only terminators or halt end it
  wire cntHit  = take && (count_q != 32'h0) &&
                 (remain_q == 32'h1);
  // whichever comes first ends the input
  wire endNow  = halt_call || termHit ||
                 (cntHit && !autoUse_q);

  // per-transfer terminator selection at start
  wire t1Dflt = isDflt(term1Sel);
  wire t2Dflt = t1Dflt || isDflt(term2Sel);

  // ----------------------------------------------------------
  // dma mode register; unloaded value is single, no auto
  // ----------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      single_q    <= 1'b1;
      modeError_q <= 1'b0;
      autoArmed_q <= 1'b0;
    end else begin
      if (dmaModeLoad) begin
        // both bus modes at once is flagged and run as single
        modeError_q <= dmaMode[`GRD_DMA_BURST_BIT] &&
                       dmaMode[`GRD_DMA_HOLD_BIT];
        single_q    <= !dmaMode[`GRD_DMA_HOLD_BIT] ||
                       dmaMode[`GRD_DMA_BURST_BIT];
        autoArmed_q <= dmaMode[`GRD_DMA_AUTO_BIT];
      end else if (running && endNow) begin
        // completion disarms auto; a load in the same cycle wins
        autoArmed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // transfer parameters, latched on start
  // ----------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dmaOn_q    <= 1'b0;
      cont_q     <= 1'b0;
      autoUse_q  <= 1'b0;
      count_q    <= 32'h0;
      startOff_q <= 16'h0;
      page_q     <= 8'h0;
      eoiUse_q   <= 1'b0;
      t1En_q     <= 1'b0;
      t1_q       <= 8'h0;
      t2En_q     <= 1'b0;
      t2_q       <= 8'h0;
    end else if (start && !running) begin
      dmaOn_q    <= xferMode[`GRD_XFER_DMA_BIT];
      cont_q     <= xferMode[`GRD_XFER_CONT_BIT] &&
                    xferMode[`GRD_XFER_DMA_BIT];
      // auto only means something for dma
      autoUse_q  <= autoArmed_q &&
                    xferMode[`GRD_XFER_DMA_BIT];
      count_q    <= byteCount;
      startOff_q <= bufOffset;
      page_q     <= bufPage;
      // eoi: default, off, or on
      if (eoiSel == `GRD_SEL_OFF) begin
        eoiUse_q <= 1'b0;
      end else if (eoiSel == `GRD_SEL_ON) begin
        eoiUse_q <= 1'b1;
      end else begin
        eoiUse_q <= dfltEoi;
      end
      // first terminator: override byte or stored default
      if (t1Dflt) begin
        t1En_q <= dfltTerm1En;
        t1_q   <= dfltTerm1;
      end else begin
        t1En_q <= 1'b1;
        t1_q   <= term1Sel[7:0];
      end
      // second terminator: forced default when first is default
      if (t2Dflt) begin
        t2En_q <= dfltTerm2En && (t1Dflt ? dfltTerm1En : 1'b1);
        t2_q   <= dfltTerm2;
      end else begin
        t2En_q <= 1'b1;
        t2_q   <= term2Sel[7:0];
      end
    end
  end

  // ----------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q   <= S_IDLE;
      busHold_q <= 1'b0;
      lowCnt_q  <= 2'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          busHold_q <= 1'b0;
          lowCnt_q  <= 2'h0;
          if (start) begin
            // pio parks in wait and takes bytes from there
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (endNow) begin
            state_q <= S_IDLE;
          end else if (dmaOn_q && rxValid) begin
            // request seen: take the bus
            state_q   <= S_XFER;
            busHold_q <= 1'b1;
          end
        end
        S_XFER: begin
          lowCnt_q <= 2'h0;
          if (endNow) begin
            state_q   <= S_IDLE;
            busHold_q <= 1'b0;
          end else if (single_q) begin
            if (take) begin
              // one byte moved: bus back to processor
              state_q   <= S_WAIT;
              busHold_q <= 1'b0;
            end
          end else if (!rxValid) begin
            // demand: keep bus, start counting low cycles
            state_q  <= S_HOLD;
            lowCnt_q <= 2'h1;
          end
        end
        default: begin
          // S_HOLD: bus kept, request low
          if (endNow) begin
            state_q   <= S_IDLE;
            busHold_q <= 1'b0;
          end else if (rxValid) begin
            state_q  <= S_XFER;
            lowCnt_q <= 2'h0;
          end else if (lowCnt_q == `GRD_HOLD_LOW_CYC) begin
            // low for three cycles in a row: release
            state_q   <= S_WAIT;
            busHold_q <= 1'b0;
            lowCnt_q  <= 2'h0;
          end else begin
            lowCnt_q <= lowCnt_q + 2'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // byte datapath: count, address, terminator history
  // ----------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      remain_q    <= 32'h0;
      off_q       <= 16'h0;
      prevT1_q    <= 1'b0;
      memWr_q     <= 1'b0;
      memAddr_q   <= 24'h0;
      memData_q   <= 8'h0;
      pioStrobe_q <= 1'b0;
      pioData_q   <= 8'h0;
    end else begin
      memWr_q     <= 1'b0;
      pioStrobe_q <= 1'b0;
      if (start && !running) begin
        remain_q <= byteCount;
        off_q    <= bufOffset;
        prevT1_q <= 1'b0;
      end else if (take) begin
        if (dmaOn_q) begin
          memWr_q   <= 1'b1;
          memAddr_q <= {page_q, off_q};
          memData_q <= rxData;
        end else begin
          pioStrobe_q <= 1'b1;
          pioData_q   <= rxData;
        end
        prevT1_q <= (rxData == t1_q);
        if (cntHit && autoUse_q) begin
          // reload and go round again; offset wraps in page
          remain_q <= count_q;
          off_q    <= startOff_q;
        end else begin
          remain_q <= remain_q - 32'h1;
          off_q    <= off_q + 16'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // completion and early return
  // ----------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_q       <= 1'b0;
      doneCause_q  <= `GRD_CAUSE_NONE;
      hostReturn_q <= 1'b0;
      first_q      <= 1'b0;
    end else begin
      done_q       <= 1'b0;
      hostReturn_q <= 1'b0;
      if (start && !running) begin
        first_q <= 1'b1;
        // no timeout to check: return at once
        if (xferMode[`GRD_XFER_CONT_BIT] && xferMode[`GRD_XFER_DMA_BIT] &&
            timeoutZero) begin
          hostReturn_q <= 1'b1;
          first_q      <= 1'b0;
        end
      end else if (running) begin
        if (endNow) begin
          done_q <= 1'b1;
          if (halt_call) begin
            doneCause_q <= `GRD_CAUSE_HALT;
          end else if (termHit) begin
            doneCause_q <= `GRD_CAUSE_TERM;
          end else begin
            doneCause_q <= `GRD_CAUSE_COUNT;
          end
          // blocking calls return only at completion
          hostReturn_q <= !cont_q || first_q;
          first_q      <= 1'b0;
        end else if (take && first_q && cont_q) begin
          // first byte in: timeout checked, hand back control
          hostReturn_q <= 1'b1;
          first_q      <= 1'b0;
        end
      end
    end
  end

endmodule

// file: shared/grd_defines.vh
// constants for the gpib receive dma control block
`ifndef GRD_DEFINES_VH
`define GRD_DEFINES_VH

// ------------------------------------------------------------
// dma mode word fields
// ------------------------------------------------------------
`define GRD_DMA_AUTO_BIT   0
`define GRD_DMA_HOLD_BIT   1
`define GRD_DMA_BURST_BIT  2
`define GRD_DMA_MODE_RST   16'h0004

// ------------------------------------------------------------
// transfer mode word fields
// ------------------------------------------------------------
`define GRD_XFER_DMA_BIT   0
`define GRD_XFER_CONT_BIT  1

// ------------------------------------------------------------
// per-transfer selector codes
// ------------------------------------------------------------
`define GRD_SEL_DEFAULT    16'hffff
`define GRD_SEL_OFF        16'h0000
`define GRD_SEL_ON         16'h0001

// ------------------------------------------------------------
// completion causes
// ------------------------------------------------------------
`define GRD_CAUSE_NONE     2'h0
`define GRD_CAUSE_COUNT    2'h1
`define GRD_CAUSE_TERM     2'h2
`define GRD_CAUSE_HALT     2'h3

// ------------------------------------------------------------
// timing: demand release after request low this many cycles plus one
// ------------------------------------------------------------
`define GRD_HOLD_LOW_CYC   2'h2

`endif

// file: tb/grd_receive_dma_bench.sv
// testbench: receive calls against the talker model with expected results
module grd_receive_dma_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rstn = 1'b0, dmaModeLoad = 1'b0, start = 1'b0, halt_call = 1'b0;
  logic dfltEoi = 1'b0, dfltTerm1En = 1'b0, dfltTerm2En = 1'b0, timeoutZero = 1'b0;
  logic [7:0]  dfltTerm1 = 8'h0d, dfltTerm2 = 8'h0a, bufPage = 8'h12, memData_q, pioData_q;
  logic [15:0] dmaMode = 16'h0004, xferMode = 16'h0000, bufOffset = 16'h0100;
  logic [15:0] eoiSel = 16'hffff, term1Sel = 16'hffff, term2Sel = 16'hffff;
  logic [31:0] byteCount = 32'h0;
  logic [23:0] memAddr_q, wA[16]; // write addresses seen
  logic [1:0]  doneCause_q, dCause;
  logic rxValid, rxEoi, rxReady, dmaReq, busHold_q, memWr_q, pioStrobe_q, busy;
  logic modeError_q, autoArmed_q, hostReturn_q, done_q, dn, hr;
  logic [7:0]  rxData, pD;
  int error_cnt = 0, checks = 0, wN = 0, pN = 0, i;
  always #25 clk_sys = ~clk_sys;
  grd_receive_dma dut_u (.clk_sys, .rstn, .dmaModeLoad, .dmaMode, .dfltEoi, .dfltTerm1En,
    .dfltTerm1, .dfltTerm2En, .dfltTerm2, .start, .xferMode, .byteCount, .bufPage, .bufOffset,
    .eoiSel, .term1Sel, .term2Sel, .timeoutZero, .halt_call, .rxValid, .rxData, .rxEoi, .rxReady,
    .dmaReq, .busHold_q, .memWr_q, .memAddr_q, .memData_q, .pioStrobe_q, .pioData_q, .busy,
    .modeError_q, .autoArmed_q, .hostReturn_q, .done_q, .doneCause_q);
  grd_talker tk_u (.clk_sys, .rxReady, .rxValid, .rxData, .rxEoi);
  // ------------------------------------------------------------
  // monitor: collects writes, strobes and the completion cause
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (memWr_q) begin
      wA[wN] = memAddr_q;
      wN++;
    end
    if (pioStrobe_q) begin
      pN++;
      pD = pioData_q;
    end
    if (hostReturn_q && !done_q) hr = 1'b1;
    if (done_q) begin
      dn = 1'b1;
      dCause = doneCause_q;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // mode word loaded with a one-cycle pulse
  task automatic cfg(input logic [15:0] m);
    @(negedge clk_sys);
    dmaMode = m;
    dmaModeLoad = 1'b1;
    @(negedge clk_sys);
    dmaModeLoad = 1'b0;
  endtask
  // one receive call; the block is idle here since every call is waited out
  task automatic run(input logic [15:0] xm, input logic [31:0] cnt, input logic [15:0] es,
                     input logic [15:0] t1, input logic [15:0] t2);
    @(negedge clk_sys);
    {wN, pN, dn, hr} = '0;
    {xferMode, byteCount, eoiSel, term1Sel, term2Sel} = {xm, cnt, es, t1, t2};
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
  endtask
  // bounded wait for completion, then cause and byte count
  task automatic fin(input logic [1:0] cause, input logic [31:0] n);
    for (i = 0; i < 400 && !dn; i++) @(negedge clk_sys);
    if (!dn) begin
      error_cnt++;
      summarize();
    end else begin
      chk(dCause, cause);
      chk(wN + pN, n);
      $display("test done at %0t", $time);
    end
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    chk({busy, autoArmed_q, modeError_q}, 3'h0);
    tk_u.q = '{9'h011, 9'h022, 9'h133}; // demand, end on eoi, no count, slow talker
    tk_u.gap = 3;
    cfg(16'h0002);
    run(16'h0001, 32'h0, 16'h0001, 16'hffff, 16'hffff);
    fin(2'h2, 3);
    tk_u.gap = 0;
    cfg(16'h0006);
    chk(modeError_q, 1'b1);
    cfg(16'h0004);
    chk(modeError_q, 1'b0);
    tk_u.q = '{9'h144, 9'h00d}; // eoi ignored, first terminator overridden
    run(16'h0001, 32'h0, 16'h0000, 16'h000d, 16'hffff);
    fin(2'h2, 2);
    {dfltTerm1En, dfltTerm2En} = 2'h3;
    tk_u.q = '{9'h00d, 9'h00a}; // default pair ends before count
    run(16'h0001, 32'h3, 16'h0000, 16'hffff, 16'h00ff);
    fin(2'h2, 2);
    tk_u.q = '{9'h00d, 9'h055, 9'h00d, 9'h00a}; // default first forces default pair
    run(16'h0001, 32'h0, 16'h0000, 16'hffff, 16'h0055);
    fin(2'h2, 4);
    tk_u.q = '{9'h00d, 9'h055}; // both overridden
    run(16'h0001, 32'h0, 16'h0000, 16'h000d, 16'h0055);
    fin(2'h2, 2);
    dfltTerm2En = 1'b0;
    cfg(16'h0005);
    chk(autoArmed_q, 1'b1);
    tk_u.q = '{9'h001, 9'h002, 9'h003, 9'h00d}; // auto reload returns to the start offset, completion disarms
    run(16'h0001, 32'h2, 16'h0000, 16'hffff, 16'hffff);
    fin(2'h2, 4);
    chk(wA[2], 24'h120100);
    chk(autoArmed_q, 1'b0);
    tk_u.q = '{9'h066, 9'h077}; // programmed transfer ends on count
    run(16'h0000, 32'h2, 16'h0000, 16'hffff, 16'hffff);
    fin(2'h1, 2);
    chk(pD, 8'h77);
    dfltTerm1En = 1'b0;
    cfg(16'h0005);
    tk_u.gap = 3;
    tk_u.q = '{9'h088, 9'h099}; // early return with repeat keeps cycling
    run(16'h0003, 32'h1, 16'h0000, 16'hffff, 16'hffff);
    for (i = 0; i < 100 && wN < 2; i++) @(negedge clk_sys);
    if (wN < 2) begin
      error_cnt++;
      summarize();
    end
    chk({hr, dn}, 2'h2);
    chk(wA[1], 24'h120100);
    halt_call = 1'b1;
    @(negedge clk_sys);
    halt_call = 1'b0;
    fin(2'h3, 2);
    {dfltEoi, timeoutZero} = 2'h3;
    tk_u.q = '{9'h1ab}; // zero timeout returns before any byte, default eoi ends it
    run(16'h0003, 32'h0, 16'hffff, 16'hffff, 16'hffff);
    @(negedge clk_sys);
    chk(hr, 1'b1);
    chk(wN, 0);
    fin(2'h2, 1);
    summarize();
  end
endmodule

// file: tb/grd_receive_dma_props.sv
// checker: timing relations at the receive dma ports
`include "grd_defines.vh"
module grd_receive_dma_props (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // control inputs
  input wire logic        dmaModeLoad,
  input wire logic [15:0] dmaMode,
  input wire logic        start,
  input wire logic        halt_call,
  input wire logic        rxValid,
  input wire logic [7:0]  rxData,
  // observed outputs
  input wire logic        rxReady,
  input wire logic        dmaReq,
  input wire logic        busHold_q,
  input wire logic        memWr_q,
  input wire logic [7:0]  memData_q,
  input wire logic        busy,
  input wire logic        modeError_q,
  input wire logic        autoArmed_q,
  input wire logic        done_q,
  input wire logic [1:0]  doneCause_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic holdQ; // demand mode in force, single wins when both are set
  // ------------------------------------------------------------
  // mode tracking
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) holdQ <= 1'b0;
    else if (dmaModeLoad) holdQ <= dmaMode[1] && !dmaMode[2];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_single_one_byte: assert property (!holdQ && busHold_q && rxReady && rxValid |=> !busHold_q)
    else $error("single mode kept the bus after one byte");
  a_demand_release: assert property (holdQ && $fell(busHold_q) && busy |-> !$past(rxValid) && !$past(rxValid, 2))
    else $error("demand mode released the bus too early");
  a_mode_error: assert property (dmaModeLoad |=> modeError_q == ($past(dmaMode[1]) && $past(dmaMode[2])))
    else $error("mode conflict flag wrong");
  a_auto_armed: assert property (dmaModeLoad |=> autoArmed_q == $past(dmaMode[0]))
    else $error("auto armed flag wrong after load");
  a_byte_written: assert property (busHold_q && rxReady && rxValid |=> memWr_q && memData_q == $past(rxData))
    else $error("taken byte not written next cycle");
  a_done_pulse: assert property (done_q |-> !busy ##1 !done_q)
    else $error("completion not a single pulse in idle");
  a_start_busy: assert property (start && !busy |=> busy)
    else $error("start did not make the block busy");
  a_halt_ends: assert property (halt_call && busy |=> done_q && doneCause_q == `GRD_CAUSE_HALT)
    else $error("halt did not end the transfer");
  a_req_takes_bus: assert property (dmaReq && !busHold_q |=> busHold_q || !busy)
    else $error("request did not take the bus");
endmodule
bind grd_receive_dma grd_receive_dma_props chk_u (.clk_sys, .rstn, .dmaModeLoad, .dmaMode,
  .start, .halt_call, .rxValid, .rxData, .rxReady, .dmaReq, .busHold_q, .memWr_q, .memData_q,
  .busy, .modeError_q, .autoArmed_q, .done_q, .doneCause_q);

// file: tb/grd_talker.sv
// talker model: offers queued bytes to the receive path one at a time
module grd_talker (
  // clock
  input  wire logic       clk_sys,
  // byte handshake
  input  wire logic       rxReady,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxEoi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] q[$];        // queued bytes, bit 8 is the end flag
  int         gap = 0;     // bytes back to back when zero, else this many plus one idle cycles between bytes (slow talker)
  int         idle = 0;    // cycles since the last byte went
  logic       took = 1'b0; // byte taken at the last rising edge
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    rxEoi   = 1'b0;
  end
  // ------------------------------------------------------------
  // handshake
  // ------------------------------------------------------------
  // the taken mark is sampled on the rising edge, acted on at the falling one
  always @(posedge clk_sys) took <= rxValid && rxReady;
  // a byte stands until taken; a released line shows inverted data so no stale byte looks valid
  always @(negedge clk_sys) begin
    if (took) begin
      void'(q.pop_front());
      idle <= 0;
      if (q.size() > 0 && gap == 0) {rxEoi, rxData} <= q[0];
      else begin
        rxValid <= 1'b0;
        rxData  <= ~rxData;
        rxEoi   <= 1'b0;
      end
    end else if (!rxValid && q.size() > 0 && idle >= gap) begin
      rxValid          <= 1'b1;
      {rxEoi, rxData}  <= q[0];
    end else idle <= idle + 1;
  end
endmodule
